// *** hw/i2cm_master.sv ***
// two-wire single-master controller with an AXI4-Lite register slave
`timescale 1ns/100ps
// Functional notes
// - slave holding clock low stalls the master
// - time low, release, wait high, time high
// - begin bit makes start, self-clears at address
// - address loaded, sent, acknowledge awaited
// - transmit shifts buffered bytes, fetches next ones
// - stop-request bit marks the final byte
// - after last transmit ack: restart or stop
// - after receive nack: restart or stop
// - address nack: stop and flag
// - data nack: stop and flag
// - empty transmit holding byte: stop, underflow flag
// - unread receive byte: nack, stop, overrun flag
// - error holds until status read clears it
// - receive stores bytes, nacks the last
// - soft clear finishes byte, stops, clears state
// - soft clear keeps target register
// - target: direction bit 7, address 6:0
// - clean finish set at stop, cleared at start
// - buffer flags follow data writes and reads
// - eight bits msb first plus acknowledge
module i2cm_master (
  input  wire logic                  mclk,
  input  wire logic                  nrst,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [i2cm_pkg::AW-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [i2cm_pkg::DW-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic [1:0]                 bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [i2cm_pkg::AW-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic [i2cm_pkg::DW-1:0]    rdata,
  output logic [1:0]                 rresp,
  input  wire logic                  sclIn,
  output logic                       sclOut,
  output logic                       sclOe,
  input  wire logic                  sdaIn,
  output logic                       sdaOut,
  output logic                       sdaOe,
  output logic                       controllerIrqOut
);
  import i2cm_pkg::*;

  i2cm_eng_t          eng;
  i2cm_eng_t          next_eng;
  i2cm_regs_t         rf;
  i2cm_regs_t         next_rf;
  logic               sclMeta;
  logic               sclSync;
  logic               sdaMeta;
  logic               sdaSync;
  logic               next_irq;
  logic               next_awready;
  logic               next_bvalid;
  logic [1:0]         next_bresp;
  logic               next_arready;
  logic               next_rvalid;
  logic [DW-1:0]      next_rdata;
  logic [1:0]         next_rresp;
  logic               wrEn;
  logic               rdEn;

  // bus handshakes of this cycle
  assign wrEn = awvalid && awready && wvalid && wready;
  assign rdEn = arvalid && arready;

  // two-flop synchronisers for the open-drain lines
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
    end else begin
      sclMeta <= sclIn;
      sclSync <= sclMeta;
      sdaMeta <= sdaIn;
      sdaSync <= sdaMeta;
    end
  end

  // bus slave: ready pulses once both address and data wait
  always_comb begin
    next_awready = 1'b0;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_arready = 1'b0;
    next_rvalid  = rvalid && !rready;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid && wvalid && !awready && !bvalid) begin
      next_awready = 1'b1;
    end
    if (wrEn) begin
      next_bvalid = 1'b1;
      next_bresp  = (awaddr inside {ADDR_CTRL, ADDR_TARGET, ADDR_STAT, ADDR_BUF,
                                    ADDR_IEN, ADDR_TXD, ADDR_RXD}) ? RESP_OKAY
                                                                    : RESP_SLVERR;
    end
    if (arvalid && !arready && !rvalid) begin
      next_arready = 1'b1;
    end
    if (rdEn) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      unique case (araddr)
        ADDR_CTRL:   next_rdata[2:0] = {rf.softClr, rf.stopReq, rf.beginXfer};
        ADDR_TARGET: next_rdata[7:0] = rf.target;
        ADDR_STAT:   next_rdata[4:0] = rf.stat;
        ADDR_BUF: begin
          next_rdata[BUF_TXE] = !rf.txFull;
          next_rdata[BUF_TXF] = rf.txFull;
          next_rdata[BUF_RXE] = !rf.rxFull;
          next_rdata[BUF_RXF] = rf.rxFull;
        end
        ADDR_IEN:    next_rdata[7:0] = rf.ien;
        ADDR_TXD:    next_rdata[7:0] = rf.txHold;
        ADDR_RXD:    next_rdata[7:0] = rf.rxHold;
        default:     next_rresp = RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      awready <= next_awready;
      wready  <= next_awready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // controller: reads clear first, then the engine sets, then software writes
  always_comb begin
    logic drv;
    logic step;
    logic softDone;
    logic rxData;
    drv      = 1'b0;
    step     = 1'b0;
    softDone = 1'b0;
    next_eng = eng;
    next_rf  = rf;
    rxData   = eng.isRx && !eng.isAddr;
    // status read clears flags; begin bit only when an error stood
    if (rdEn && araddr == ADDR_STAT) begin
      if (|rf.stat[4:1]) begin
        next_rf.beginXfer = 1'b0;
      end
      next_rf.stat = '0;
    end
    if (rdEn && araddr == ADDR_RXD) begin
      next_rf.rxFull = 1'b0;
    end
    // level put on the data line during the low half of the slot
    unique case (eng.st)
      SM_STOP: drv = 1'b1;
      SM_BYTE: begin
        if (eng.bitCnt == ACK_SLOT) begin
          drv = rxData && !(rf.stopReq || eng.overrun || rf.softClr);
        end else begin
          drv = !rxData && !eng.sh[7];
        end
      end
      default: drv = 1'b0;
    endcase
    // bit phase timing shared by start, byte and stop
    unique case (eng.st)
      SM_IDLE: begin
        next_eng.sclOe = 1'b0;
        next_eng.sdaOe = 1'b0;
        if (rf.softClr) begin
          softDone = 1'b1;
        end else if (rf.beginXfer) begin
          next_eng.st     = SM_START;
          next_eng.ph     = PH_LOW;
          next_eng.cnt    = '0;
          next_eng.bitCnt = '0;
        end
      end
      SM_HOLD: begin
        if (rf.softClr) begin
          softDone = 1'b1;
        end else if (rdEn && araddr == ADDR_STAT) begin
          next_eng.st  = SM_IDLE;
          next_eng.err = 1'b0;
        end
      end
      default: begin
        unique case (eng.ph)
          PH_LOW: begin
            next_eng.cnt = eng.cnt + 1'b1;
            if (eng.cnt == LOW_MID) begin
              next_eng.sdaOe = drv;
            end
            if (eng.cnt == LOW_LAST) begin
              next_eng.sclOe = 1'b0;
              next_eng.ph    = PH_WAIT;
            end
          end
          PH_WAIT: begin
            if (sclSync) begin
              next_eng.ph  = PH_HIGH;
              next_eng.cnt = '0;
              if (eng.bitCnt == ACK_SLOT) begin
                next_eng.nack = sdaSync;
              end else begin
                next_eng.sh = {eng.sh[6:0], sdaSync};
              end
            end
          end
          PH_HIGH: begin
            next_eng.cnt = eng.cnt + 1'b1;
            if (eng.cnt == HIGH_LAST) begin
              next_eng.cnt = '0;
              step         = 1'b1;
            end
          end
          default: next_eng.ph = PH_LOW;
        endcase
      end
    endcase
    // end of a high period: advance the frame
    if (step) begin
      unique case (eng.st)
        SM_START: begin
          if (eng.bitCnt == '0) begin
            next_eng.sdaOe  = 1'b1;
            next_eng.bitCnt = 4'h1;
          end else begin
            next_eng.sclOe  = 1'b1;
            next_eng.st     = SM_BYTE;
            next_eng.ph     = PH_LOW;
            next_eng.bitCnt = '0;
            next_eng.isAddr = 1'b1;
            next_eng.isRx   = rf.target[DIR_BIT];
            next_eng.sh     = {rf.target[6:0], rf.target[DIR_BIT]};
            next_eng.overrun = 1'b0;
            next_rf.beginXfer   = 1'b0;
            next_rf.stat[ST_END] = 1'b0;
          end
        end
        SM_BYTE: begin
          next_eng.sclOe  = 1'b1;
          next_eng.ph     = PH_LOW;
          next_eng.bitCnt = eng.bitCnt + 1'b1;
          if (eng.bitCnt == LAST_BIT && rxData) begin
            if (next_rf.rxFull) begin
              next_eng.overrun = 1'b1;
            end else begin
              next_rf.rxHold = eng.sh;
              next_rf.rxFull = 1'b1;
            end
          end
          if (eng.bitCnt == ACK_SLOT) begin
            next_eng.bitCnt = '0;
            next_eng.isAddr = 1'b0;
            next_eng.st     = SM_STOP;
            if (eng.isAddr && eng.nack) begin
              next_rf.stat[ST_ANACK] = 1'b1;
              next_eng.err = 1'b1;
            end else if (!eng.isRx && !eng.isAddr && eng.nack) begin
              next_rf.stat[ST_DNACK] = 1'b1;
              next_eng.err = 1'b1;
            end else if (eng.overrun) begin
              next_rf.stat[ST_OVERRUN] = 1'b1;
              next_eng.err = 1'b1;
            end else if (rf.softClr) begin
              next_eng.st = SM_STOP;
            end else if (!eng.isAddr && rf.stopReq) begin
              next_rf.stopReq = 1'b0;
              next_eng.st = rf.beginXfer ? SM_START : SM_STOP;
            end else if (eng.isRx) begin
              next_eng.st = SM_BYTE;
            end else if (rf.txFull) begin
              next_eng.st    = SM_BYTE;
              next_eng.sh    = rf.txHold;
              next_rf.txFull = 1'b0;
            end else begin
              next_rf.stat[ST_UNDER] = 1'b1;
              next_eng.err = 1'b1;
            end
          end
        end
        default: begin
          next_eng.sdaOe = 1'b0;
          if (eng.err) begin
            next_eng.st = SM_HOLD;
          end else if (rf.softClr) begin
            softDone = 1'b1;
          end else begin
            next_eng.st = SM_IDLE;
            next_rf.stat[ST_END] = 1'b1;
          end
        end
      endcase
    end
    // soft clear wipes control, status and engine, keeps the target
    if (softDone) begin
      next_eng.st      = SM_IDLE;
      next_eng.ph      = PH_LOW;
      next_eng.cnt     = '0;
      next_eng.bitCnt  = '0;
      next_eng.err     = 1'b0;
      next_eng.overrun = 1'b0;
      next_eng.sclOe   = 1'b0;
      next_eng.sdaOe   = 1'b0;
      next_rf.beginXfer = 1'b0;
      next_rf.stopReq  = 1'b0;
      next_rf.softClr  = 1'b0;
      next_rf.stat     = '0;
    end
    // software writes
    if (wrEn && wstrb[0]) begin
      unique case (awaddr)
        ADDR_CTRL: begin
          next_rf.beginXfer = wdata[CTL_BEGIN];
          next_rf.stopReq   = wdata[CTL_STOP];
          next_rf.softClr   = wdata[CTL_SOFT];
        end
        ADDR_TARGET: next_rf.target = wdata[7:0];
        ADDR_IEN:    next_rf.ien = wdata[7:0];
        ADDR_TXD: begin
          if (!rf.txFull) begin
            next_rf.txHold = wdata[7:0];
            next_rf.txFull = 1'b1;
          end
        end
        default: next_rf.ien = next_rf.ien;
      endcase
    end
    // interrupt from every enabled flag
    next_irq = |(rf.stat & rf.ien[4:0])
             | (rf.ien[IEN_TXE] & !rf.txFull)
             | (rf.ien[IEN_RXF] & rf.rxFull)
             | (rf.ien[IEN_TXF] & rf.txFull);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      eng <= '{st: SM_IDLE, ph: PH_LOW, default: '0};
      rf  <= '0;
      controllerIrqOut <= 1'b0;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end else begin
      eng <= next_eng;
      rf  <= next_rf;
      controllerIrqOut <= next_irq;
      sclOut <= 1'b0;
      sdaOut <= 1'b0;
    end
  end

  assign sclOe = eng.sclOe;
  assign sdaOe = eng.sdaOe;
endmodule // i2cm_master

// *** pkg/i2cm_pkg.sv ***
// constants, register map and carrier types of the two-wire master controller
package i2cm_pkg;
  // bus geometry
  localparam int AW = 8;
  localparam int DW = 32;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_BUF    = 8'h0C;
  localparam logic [7:0] ADDR_IEN    = 8'h10;
  localparam logic [7:0] ADDR_TXD    = 8'h14;
  localparam logic [7:0] ADDR_RXD    = 8'h18;
  // control register fields
  localparam int CTL_BEGIN = 0;
  localparam int CTL_STOP  = 1;
  localparam int CTL_SOFT  = 2;
  // target register: direction in bit 7, address in 6:0
  localparam int DIR_BIT = 7;
  // status fields: clean finish, then the error flags
  localparam int ST_END     = 0;
  localparam int ST_OVERRUN = 1;
  localparam int ST_UNDER   = 2;
  localparam int ST_ANACK   = 3;
  localparam int ST_DNACK   = 4;
  // buffer status fields
  localparam int BUF_RXF = 0;
  localparam int BUF_RXE = 2;
  localparam int BUF_TXF = 3;
  localparam int BUF_TXE = 5;
  // interrupt enable fields beyond the status bits
  localparam int IEN_TXE = 5;
  localparam int IEN_RXF = 6;
  localparam int IEN_TXF = 7;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // line timing
  localparam int CLK_MHZ   = 100;
  localparam int T_LOW_NS  = 5000;
  localparam int T_HIGH_NS = 5000;
  localparam int LOW_CYC   = (T_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int HIGH_CYC  = (T_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W     = 12;
  localparam logic [CNT_W-1:0] LOW_LAST  = CNT_W'(LOW_CYC - 1);
  localparam logic [CNT_W-1:0] LOW_MID   = CNT_W'(LOW_CYC / 2);
  localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(HIGH_CYC - 1);
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // controller states and bit phases
  typedef enum logic [4:0] {
    SM_IDLE  = 5'b00001,
    SM_START = 5'b00010,
    SM_BYTE  = 5'b00100,
    SM_STOP  = 5'b01000,
    SM_HOLD  = 5'b10000
  } i2cm_st_t;
  typedef enum logic [2:0] {
    PH_LOW  = 3'b001,
    PH_WAIT = 3'b010,
    PH_HIGH = 3'b100
  } i2cm_ph_t;
  // shift engine state
  typedef struct packed {
    i2cm_st_t         st;
    i2cm_ph_t         ph;
    logic [CNT_W-1:0] cnt;
    logic [3:0]       bitCnt;
    logic [7:0]       sh;
    logic             sclOe;
    logic             sdaOe;
    logic             isAddr;
    logic             isRx;
    logic             err;
    logic             nack;
    logic             overrun;
  } i2cm_eng_t;
  // software visible state
  typedef struct packed {
    logic       beginXfer;
    logic       stopReq;
    logic       softClr;
    logic [7:0] target;
    logic [4:0] stat;
    logic [7:0] ien;
    logic [7:0] txHold;
    logic       txFull;
    logic [7:0] rxHold;
    logic       rxFull;
  } i2cm_regs_t;
endpackage

// *** tb/i2cm_monitor.sv ***
// checker for the two-wire master: bus answers and clock line timing
`timescale 1ns/100ps
module i2cm_monitor (
  input wire logic                    mclk,
  input wire logic                    nrst,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [i2cm_pkg::DW-1:0] rdata,
  input wire logic                    sclIn,
  input wire logic                    sclOut,
  input wire logic                    sclOe,
  input wire logic                    sdaOe
);
  import i2cm_pkg::*;
  logic [15:0] hiCnt;
  logic [15:0] next_hiCnt;
  logic [15:0] loCnt;
  logic [15:0] next_loCnt;
  // run length of a high clock line and of the master's own pull
  always_comb begin
    next_hiCnt = sclIn ? hiCnt + 16'h1 : 16'h0;
    next_loCnt = sclOe ? loCnt + 16'h1 : 16'h0;
  end
  // register the run lengths
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      hiCnt <= 16'h0;
      loCnt <= 16'h0;
    end else begin
      hiCnt <= next_hiCnt;
      loCnt <= next_loCnt;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  AST_STRETCH_WAIT: assert property (!sclOe && !sclIn |=> !sclOe)
    else $error("clock pulled again while held low by the slave");
  AST_HIGH_TIME: assert property ($rose(sclOe) |-> hiCnt >= HIGH_CYC - 1)
    else $error("clock high period too short");
  AST_LOW_TIME: assert property ($fell(sclOe) |-> loCnt >= LOW_CYC - 2 && loCnt <= LOW_CYC + 6)
    else $error("clock low period off");
  AST_SDA_MID: assert property (sclOe && $changed(sdaOe) |->
    loCnt >= LOW_CYC / 2 - 2 && loCnt <= LOW_CYC / 2 + 6)
    else $error("data changed away from mid low");
  AST_OPEN_DRAIN: assert property (sclOe |-> !sclOut)
    else $error("clock driven high");
  AST_WR_ANSWER: assert property (awvalid && awready |=> bvalid)
    else $error("write response late");
  AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  COV_STRETCH: cover property (!sclOe && !sclIn);
  COV_WRITE: cover property (bvalid && bready);
  COV_READ: cover property (rvalid && rready);
endmodule // i2cm_monitor

bind i2cm_master i2cm_monitor i2cm_monitor_inst (
  .mclk(mclk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
  .sdaOe(sdaOe)
);

// *** tb/i2cm_slave_model.sv ***
// behavioural two-wire slave: acks its address, stretches, one byte each way
`timescale 1ns/100ps
module i2cm_slave_model #(
  parameter logic [6:0] SELF = 7'h2A
) (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] txByte,
  output logic            sdaPull,
  output logic            sclPull,
  output logic [7:0]      rxByte,
  output logic            lastAck
);
  logic [7:0] sh;
  logic       hit;
  // eight bits, msb first, sampled while the clock is high
  task automatic getByte();
    for (int i = 0; i < 8; i++) begin
      @(posedge scl);
      sh = {sh[6:0], sda};
    end
  endtask
  // one frame after a start condition
  task automatic frame();
    getByte();
    hit = (sh[7:1] == SELF);
    @(negedge scl);
    sdaPull = hit;
    @(negedge scl);
    sdaPull = 1'b0;
    if (hit) begin
      // hold the clock past the master's own low time so that it must wait;
      // the odd delay keeps the release off the system clock edges
      sclPull = 1'b1;
      sdaPull = sh[0] && !txByte[7];
      #8003;
      sclPull = 1'b0;
      if (sh[0]) begin
        for (int i = 6; i >= 0; i--) begin
          @(negedge scl);
          sdaPull = !txByte[i];
        end
        @(negedge scl);
        sdaPull = 1'b0;
        @(posedge scl);
        lastAck = sda;
      end else begin
        getByte();
        rxByte = sh;
        @(negedge scl);
        sdaPull = 1'b1;
        @(negedge scl);
        sdaPull = 1'b0;
      end
    end
  endtask
  // a stop condition ends whatever frame is under way
  initial begin
    sdaPull = 1'b0;
    sclPull = 1'b0;
    rxByte = 8'h00;
    lastAck = 1'b0;
    sh = 8'h00;
    forever begin
      @(negedge sda iff scl === 1'b1);
      fork
        frame();
        @(posedge sda iff scl === 1'b1);
      join_any
      disable fork;
      sdaPull = 1'b0;
      sclPull = 1'b0;
    end
  end
endmodule // i2cm_slave_model

// *** tb/tb.sv ***
// self-checking bench for the two-wire master controller
`timescale 1ns/100ps
module tb;
  import i2cm_pkg::*;
  localparam logic [6:0] SELF = 7'h2A;
  localparam int LIMIT = 95000;
  logic mclk, nrst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic bvalid, arready, rvalid, sclOut, sclOe, sdaOut, sdaOe, irq, slSda, slScl, lastAck;
  logic [7:0] awaddr, araddr, slTx, slRx;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lastResp;
  wire sclW = !(sclOe || slScl);
  wire sdaW = !(sdaOe || slSda);
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  i2cm_master i2cm_master_inst (
    .mclk(mclk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .controllerIrqOut(irq)
  );
  i2cm_slave_model #(.SELF(SELF)) i2cm_slave_model_inst (
    .scl(sclW), .sda(sdaW), .txByte(slTx), .sdaPull(slSda), .sclPull(slScl),
    .rxByte(slRx), .lastAck(lastAck)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // register write, both channels held until taken
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    do @(posedge mclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge mclk); while (bvalid !== 1'b1);
    // response is left waiting one cycle, then taken
    bready <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b0;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    // data is left waiting one cycle, then taken at the handshake edge
    rready <= 1'b1;
    @(posedge mclk);
    d = rdata;
    lastResp = rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(d, exp);
  endtask
  task automatic irqIs(input logic e);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'(e));
  endtask
  task automatic waitStop();
    @(posedge sdaW iff sclW === 1'b1);
    repeat (4) @(posedge mclk);
  endtask
  task automatic t_regs();
    rc(ADDR_CTRL, 32'h0);
    rc(ADDR_BUF, 32'h24);
    rd(8'h1C);
    chk(d, 32'h0);
    chk(32'(lastResp), 32'(RESP_SLVERR));
    wr(ADDR_TARGET, {1'b0, SELF});
    wr(ADDR_CTRL, 8'h04);
    rc(ADDR_TARGET, {25'h0, SELF});
    rc(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_write();
    wr(ADDR_TXD, 8'h1D);
    rc(ADDR_BUF, 32'h0C);
    wr(ADDR_IEN, 8'h01);
    wr(ADDR_CTRL, 8'h03);
    repeat (2) @(negedge sclW);
    @(posedge mclk);
    rc(ADDR_CTRL, 32'h02);
    waitStop();
    chk({24'h0, slRx}, 32'h1D);
    irqIs(1'b1);
    rc(ADDR_CTRL, 32'h0);
    rc(ADDR_BUF, 32'h24);
    rc(ADDR_STAT, 32'h01);
    irqIs(1'b0);
  endtask
  task automatic t_under();
    wr(ADDR_IEN, 8'h04);
    wr(ADDR_CTRL, 8'h03);
    waitStop();
    irqIs(1'b1);
    rc(ADDR_STAT, 32'h04);
    irqIs(1'b0);
    wr(ADDR_CTRL, 8'h04);
    rc(ADDR_CTRL, 32'h0);
  endtask
  task automatic t_read();
    wr(ADDR_TARGET, {1'b1, SELF});
    slTx <= 8'hB4;
    wr(ADDR_CTRL, 8'h03);
    waitStop();
    chk(32'(lastAck), 32'h1);
    rc(ADDR_BUF, 32'h21);
    rc(ADDR_STAT, 32'h01);
    // second read with the first byte still unread: overrun, byte dropped
    slTx <= 8'h4B;
    wr(ADDR_CTRL, 8'h03);
    waitStop();
    rc(ADDR_STAT, 32'h02);
    wr(ADDR_CTRL, 8'h04);
    rc(ADDR_CTRL, 32'h0);
    rc(ADDR_RXD, 32'hB4);
    rc(ADDR_BUF, 32'h24);
  endtask
  task automatic t_anack();
    wr(ADDR_TARGET, {1'b0, SELF ^ 7'h01});
    wr(ADDR_TXD, 8'h33);
    wr(ADDR_IEN, 8'h08);
    wr(ADDR_CTRL, 8'h03);
    // ask for a repeated start once the address is under way
    repeat (2) @(negedge sclW);
    @(posedge mclk);
    wr(ADDR_CTRL, 8'h03);
    waitStop();
    irqIs(1'b1);
    rc(ADDR_STAT, 32'h08);
    rc(ADDR_CTRL, 32'h02);
    irqIs(1'b0);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // free-running system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // cycle ceiling against a hung wait
  always @(posedge mclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      close_out();
    end
  end
  // reset, then the scenarios in turn
  initial begin
    nrst = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'h1;
    slTx = 8'h00;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs();
    t_write();
    t_under();
    t_read();
    t_anack();
    close_out();
  end
endmodule // tb
